//--- tbeip_pkg.sv
// Package for the time-base event interrupt prescaler: register indices,
// field layouts, reset values and source select encodings.
// Assumes a 16-bit register port with word indices.
package tbeip_pkg;

  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned TB_W   = 16;

  // Register indices (byte offsets 0h..8h halved)
  localparam logic [ADDR_W-1:0] IDX_SELECT    = 3'h0;
  localparam logic [ADDR_W-1:0] IDX_PRESCALE  = 3'h1;
  localparam logic [ADDR_W-1:0] IDX_FLAG      = 3'h2;
  localparam logic [ADDR_W-1:0] IDX_CLEAR     = 3'h3;
  localparam logic [ADDR_W-1:0] IDX_FORCE     = 3'h4;

  // Field positions
  localparam int unsigned SEL_SRC_LSB  = 0;
  localparam int unsigned SEL_SRC_W    = 3;
  localparam int unsigned SEL_EN_BIT   = 3;
  localparam int unsigned PS_PRD_LSB   = 0;
  localparam int unsigned PS_CNT_LSB   = 2;
  localparam int unsigned CNT_W        = 2;
  localparam int unsigned FLAG_BIT     = 0;

  // Reset values and other constants
  localparam logic [SEL_SRC_W-1:0] SRC_RST = 3'h0;
  localparam logic [CNT_W-1:0]     CNT_RST = 2'h0;
  localparam logic [CNT_W-1:0]     PRD_OFF = 2'h0;
  localparam logic [CNT_W-1:0]     CNT_ONE = 2'h1;
  localparam logic [TB_W-1:0]      TB_ZERO = 16'h0000;
  localparam logic [DATA_W-1:0]    RD_ZERO = 16'h0000;

  // Source select encodings
  localparam logic [SEL_SRC_W-1:0] SRC_ZERO    = 3'h1;
  localparam logic [SEL_SRC_W-1:0] SRC_PERIOD  = 3'h2;
  localparam logic [SEL_SRC_W-1:0] SRC_COMPARE_A_VALUE_UP = 3'h4;
  localparam logic [SEL_SRC_W-1:0] SRC_COMPARE_A_VALUE_DN = 3'h5;
  localparam logic [SEL_SRC_W-1:0] SRC_COMPARE_B_VALUE_UP = 3'h6;
  localparam logic [SEL_SRC_W-1:0] SRC_COMPARE_B_VALUE_DN = 3'h7;

  typedef enum logic [1:0] {
    TBEIP_IDLE    = 2'b01,
    TBEIP_FLAGGED = 2'b10
  } tbeip_state_e;

endpackage

//--- tbeip_event_sel.sv
// Event source multiplexer: compares the time-base count and picks one event.
// Assumes time-base inputs are synchronous to clk_sys_in.
`timescale 1ns/1ps
module tbeip_event_sel
  import tbeip_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_sys_in,
  input  wire logic                 resetn_in,
  // Selection
  input  wire logic [SEL_SRC_W-1:0] src_sel_in,
  // Time-base values
  input  wire logic [TB_W-1:0]      timebase_count_in,
  input  wire logic [TB_W-1:0]      timebase_period_in,
  input  wire logic [TB_W-1:0]      compare_a_value_in,
  input  wire logic [TB_W-1:0]      compare_b_value_in,
  input  wire logic                 count_up_in,
  // Selected event, one cycle pulse per qualifying cycle
  output logic                      event_out
);
  logic hit_a;
  logic hit_b;
  logic event_nxt;

  assign hit_a = (timebase_count_in == compare_a_value_in);
  assign hit_b = (timebase_count_in == compare_b_value_in);

  always_comb begin
    case (src_sel_in)
      SRC_ZERO:    event_nxt = (timebase_count_in == TB_ZERO);
      SRC_PERIOD:  event_nxt = (timebase_count_in == timebase_period_in);
      SRC_COMPARE_A_VALUE_UP: event_nxt = hit_a && count_up_in;
      SRC_COMPARE_A_VALUE_DN: event_nxt = hit_a && !count_up_in;
      SRC_COMPARE_B_VALUE_UP: event_nxt = hit_b && count_up_in;
      SRC_COMPARE_B_VALUE_DN: event_nxt = hit_b && !count_up_in;
      default:     event_nxt = 1'b0;
    endcase
  end

  // Registered so a counter value that lingers produces one event per cycle held;
  // the time-base is expected to step each cycle it is meant to count.
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      event_out <= 1'b0;
    end else begin
      event_out <= event_nxt;
    end
  end
endmodule

//--- tbeip_counter.sv
// Two-bit event counter with hold at period and clear on pulse.
// Assumes inc_in and clr_in come from the owning controller.
`timescale 1ns/1ps
module tbeip_counter
  import tbeip_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             resetn_in,
  // Control
  input  wire logic             inc_in,
  input  wire logic             clr_in,
  input  wire logic             hold_in,
  input  wire logic [CNT_W-1:0] prd_in,
  // Count
  output logic      [CNT_W-1:0] count_out
);
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      count_out <= CNT_RST;
    end else if (clr_in) begin
      count_out <= CNT_RST;
    end else if (inc_in && !(hold_in && count_out == prd_in)) begin
      count_out <= count_out + CNT_ONE;
    end
  end
endmodule

//--- tbeip_top.sv
// Time-base event interrupt prescaler: selects a time-base event, counts it
// and raises a one-cycle interrupt after one to three events.
// Assumes a simple register port with read data one cycle after the strobe.
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
// Function
// - Interrupts are produced only while the enable bit 3 of select register is set.
// - Source 1h counts an event when the time-base count is zero.
// - Source 2h counts an event when the count equals the period.
// - Source 4h counts compare A matches while counting up.
// - Source 5h counts compare A matches while counting down.
// - Source 6h counts compare B matches while counting up.
// - Source 7h counts compare B matches while counting down.
// - A read-only two-bit event count reports events since the last pulse.
// - The event count clears when an interrupt pulse is produced.
// - When disabled or flagged, the count stops at the period value.
// - Bits 1-0 of the prescale register set events needed per interrupt.
// - No new pulse while the status flag stays set from an earlier one.
// - One further interrupt may pend while flagged, issued after clear.
// - Writing a period equal to the count fires if enabled and flag clear.
// - Period zero disables the counter; no interrupt and force is ignored.
// - Periods 1h, 2h, 3h fire on the first, second, third event.
// - Writing 1 to the clear bit clears the status flag.
module tbeip_top
  import tbeip_pkg::*;
(
  // Clock and reset
  input  wire logic                         clk_sys_in,
  input  wire logic                         resetn_in,
  // Register port
  input  wire logic [tbeip_pkg::ADDR_W-1:0] reg_addr_in,
  input  wire logic [tbeip_pkg::DATA_W-1:0] reg_wdata_in,
  input  wire logic                         reg_wr_in,
  input  wire logic                         reg_rd_in,
  output logic      [tbeip_pkg::DATA_W-1:0] reg_rdata_out,
  // Time-base and compare values
  input  wire logic [tbeip_pkg::TB_W-1:0]   timebase_count_in,
  input  wire logic [tbeip_pkg::TB_W-1:0]   timebase_period_in,
  input  wire logic [tbeip_pkg::TB_W-1:0]   compare_a_value_in,
  input  wire logic [tbeip_pkg::TB_W-1:0]   compare_b_value_in,
  input  wire logic                         count_up_in,
  // Interrupt
  output logic                              module_event_irq_out,
  output logic                              event_status_flag_out
);
  import tbeip_pkg::*;

  logic                 irq_enable_bit_r;
  logic [SEL_SRC_W-1:0] irq_source_select_r;
  logic [CNT_W-1:0]     irq_event_period_r;
  logic [CNT_W-1:0]     irq_event_count;
  logic                 pending_r;
  tbeip_state_e         state_r;
  tbeip_state_e         state_nxt;
  logic                 event_hit;
  logic                 wr_sel;
  logic                 wr_prd;
  logic                 wr_clr;
  logic                 wr_frc;
  logic                 flag_set;
  logic                 at_period;
  logic                 fire;
  logic                 fire_pending;
  logic [CNT_W-1:0]     cnt_after;

  assign wr_sel = reg_wr_in && (reg_addr_in == IDX_SELECT);
  assign wr_prd = reg_wr_in && (reg_addr_in == IDX_PRESCALE);
  assign wr_clr = reg_wr_in && (reg_addr_in == IDX_CLEAR) && reg_wdata_in[FLAG_BIT];
  assign wr_frc = reg_wr_in && (reg_addr_in == IDX_FORCE) && reg_wdata_in[FLAG_BIT];
  assign flag_set = (state_r == TBEIP_FLAGGED);

  // Register writes; only defined field bits are stored
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      irq_enable_bit_r    <= 1'b0;
      irq_source_select_r <= SRC_RST;
    end else if (wr_sel) begin
      irq_enable_bit_r    <= reg_wdata_in[SEL_EN_BIT];
      irq_source_select_r <= reg_wdata_in[SEL_SRC_LSB +: SEL_SRC_W];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      irq_event_period_r <= PRD_OFF;
    end else if (wr_prd) begin
      irq_event_period_r <= reg_wdata_in[PS_PRD_LSB +: CNT_W];
    end
  end

  tbeip_event_sel u_event_sel (
    .clk_sys_in         (clk_sys_in),
    .resetn_in          (resetn_in),
    .src_sel_in         (irq_source_select_r),
    .timebase_count_in  (timebase_count_in),
    .timebase_period_in (timebase_period_in),
    .compare_a_value_in (compare_a_value_in),
    .compare_b_value_in (compare_b_value_in),
    .count_up_in        (count_up_in),
    .event_out          (event_hit)
  );

  // A zero period disables counting and forcing alike
  assign cnt_after = (event_hit && irq_event_period_r != PRD_OFF) ? irq_event_count + CNT_ONE
                                                                  : irq_event_count;
  // Count reaching the period, including via a period rewrite equal to the count, or a force write
  assign at_period = (irq_event_period_r != PRD_OFF) &&
                     ((cnt_after == irq_event_period_r) ||
                      wr_frc);
  // A pending interrupt is issued once the flag drops; a zero period holds it back but keeps it pending
  assign fire_pending = pending_r && !flag_set && irq_enable_bit_r &&
                        (irq_event_period_r != PRD_OFF);
  assign fire = irq_enable_bit_r && !flag_set && (at_period || fire_pending);

  tbeip_counter u_counter (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .inc_in     (event_hit && irq_event_period_r != PRD_OFF),
    .clr_in     (fire),
    .hold_in    (!irq_enable_bit_r || flag_set),
    .prd_in     (irq_event_period_r),
    .count_out  (irq_event_count)
  );

  // Pending request: counter reached period while flagged
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      pending_r <= 1'b0;
    end else if (fire) begin
      pending_r <= 1'b0;
    end else if (flag_set && irq_enable_bit_r && at_period) begin
      pending_r <= 1'b1;
    end
  end

  // Flag state; the clear wins in its cycle and an event in that cycle pends, so no event is lost
  always_comb begin
    case (state_r)
      TBEIP_IDLE:    state_nxt = fire ? TBEIP_FLAGGED : TBEIP_IDLE;
      TBEIP_FLAGGED: state_nxt = wr_clr ? TBEIP_IDLE : TBEIP_FLAGGED;
      default:       state_nxt = TBEIP_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      state_r <= TBEIP_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      module_event_irq_out  <= 1'b0;
      event_status_flag_out <= 1'b0;
    end else begin
      module_event_irq_out  <= fire;
      event_status_flag_out <= (state_nxt == TBEIP_FLAGGED);
    end
  end

  // Read data one cycle after the strobe; unmapped and write-only read zero
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= RD_ZERO;
    end else begin
      reg_rdata_out <= RD_ZERO;
      if (reg_rd_in) begin
        case (reg_addr_in)
          IDX_SELECT: begin
            reg_rdata_out[SEL_EN_BIT]                <= irq_enable_bit_r;
            reg_rdata_out[SEL_SRC_LSB +: SEL_SRC_W]  <= irq_source_select_r;
          end
          IDX_PRESCALE: begin
            reg_rdata_out[PS_PRD_LSB +: CNT_W] <= irq_event_period_r;
            reg_rdata_out[PS_CNT_LSB +: CNT_W] <= irq_event_count;
          end
          IDX_FLAG:   reg_rdata_out[FLAG_BIT] <= flag_set;
          default:    reg_rdata_out <= RD_ZERO;
        endcase
      end
    end
  end
endmodule

//--- tbeip_top_sva.sv
// Port-level checker for the time-base event interrupt prescaler.
// Assumes a bind from the bench top; only top ports are seen.
`timescale 1ns/1ps
module tbeip_top_sva
  import tbeip_pkg::*;
(
  input wire logic              clk_sys_in,
  input wire logic              resetn_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic              reg_wr_in,
  input wire logic              reg_rd_in,
  input wire logic [DATA_W-1:0] reg_rdata_out,
  input wire logic              module_event_irq_out,
  input wire logic              event_status_flag_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  logic             en_r;
  logic [CNT_W-1:0] prd_r;
  logic             wr_clr;
  assign wr_clr = reg_wr_in && reg_addr_in == IDX_CLEAR && reg_wdata_in[0];
  // Shadow of the gating fields, updated on the same edge as the design's copy
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      en_r  <= 1'b0;
      prd_r <= PRD_OFF;
    end else if (reg_wr_in && reg_addr_in == IDX_SELECT) begin
      en_r <= reg_wdata_in[SEL_EN_BIT];
    end else if (reg_wr_in && reg_addr_in == IDX_PRESCALE) begin
      prd_r <= reg_wdata_in[1:0];
    end
  end
  AST_IRQ_PULSE: assert property (module_event_irq_out |=> !module_event_irq_out)
    else $error("irq longer than one cycle");
  AST_IRQ_FLAG: assert property (
    module_event_irq_out |-> event_status_flag_out && !$past(event_status_flag_out))
    else $error("irq while flag was set or flag not set");
  AST_FLAG_ROSE: assert property ($rose(event_status_flag_out) |-> module_event_irq_out)
    else $error("flag rose without irq");
  AST_FLAG_HOLD: assert property (event_status_flag_out && !wr_clr |=> event_status_flag_out)
    else $error("flag dropped without clear");
  AST_FLAG_CLR: assert property (event_status_flag_out && wr_clr |=> !event_status_flag_out)
    else $error("clear write ignored");
  AST_EN_GATE: assert property (!en_r |=> !module_event_irq_out)
    else $error("irq while disabled");
  AST_PRD_GATE: assert property (prd_r == PRD_OFF |=> !module_event_irq_out)
    else $error("irq with period zero");
  AST_RD_IDLE: assert property (!reg_rd_in |=> reg_rdata_out == RD_ZERO)
    else $error("read data outside read slot");
  AST_RD_FLAG: assert property (
    reg_rd_in && reg_addr_in == IDX_FLAG |=> reg_rdata_out == {15'h0, $past(event_status_flag_out)})
    else $error("flag read mismatch");
  AST_RD_UPPER: assert property (reg_rd_in && reg_addr_in <= IDX_PRESCALE |=> reg_rdata_out[15:4] == 12'h000)
    else $error("reserved bits read nonzero");
  cover property (module_event_irq_out);
  cover property (event_status_flag_out && wr_clr);
  cover property (reg_rd_in && reg_addr_in == IDX_PRESCALE);
endmodule

//--- tbeip_tb_tbase.sv
// Time-base model: presents one matching count for one cycle on request.
// Assumes go_in is a one-cycle request from the bench.
`timescale 1ns/1ps
module tbeip_tb_tbase
  import tbeip_pkg::*;
(
  input  wire logic                 clk_sys_in,
  input  wire logic                 go_in,
  input  wire logic [SEL_SRC_W-1:0] kind_in,
  output logic      [TB_W-1:0]      timebase_count_out = 16'h0005,
  output logic      [TB_W-1:0]      timebase_period_out,
  output logic      [TB_W-1:0]      compare_a_value_out,
  output logic      [TB_W-1:0]      compare_b_value_out,
  output logic                      count_up_out = 1'b1
);
  assign timebase_period_out = 16'h0040;
  assign compare_a_value_out = 16'h0010;
  assign compare_b_value_out = 16'h0020;
  // Idle count 5 matches nothing, so only requested cycles can be events
  always @(posedge clk_sys_in) begin
    count_up_out <= !(go_in && kind_in[0]);
    case (go_in ? kind_in : 3'h0)
      3'h1:       timebase_count_out <= 16'h0000;
      3'h2:       timebase_count_out <= 16'h0040;
      3'h4, 3'h5: timebase_count_out <= 16'h0010;
      3'h6, 3'h7: timebase_count_out <= 16'h0020;
      default:    timebase_count_out <= 16'h0005;
    endcase
  end
endmodule

//--- timebase_event_irq_prescaler_bench.sv
// Bench for the time-base event interrupt prescaler.
// Assumes the package, design, model and checker are compiled first.
`timescale 1ns/1ps
module timebase_event_irq_prescaler_bench;
  import tbeip_pkg::*;
  logic                 clk_sys_in = 1'b0;
  logic                 resetn_in  = 1'b0;
  logic [ADDR_W-1:0]    addr       = 3'h0;
  logic [DATA_W-1:0]    wdata      = 16'h0000;
  logic                 wr_s       = 1'b0;
  logic                 rd_s       = 1'b0;
  logic                 go         = 1'b0;
  logic [SEL_SRC_W-1:0] kind       = 3'h0;
  logic [DATA_W-1:0]    rdata;
  logic [TB_W-1:0]      cnt, prd, cma, cmb;
  logic                 up, irq, flag;
  int                   n_fail     = 0;
  int                   tests_run  = 0;
  logic [SEL_SRC_W-1:0] srcs [6]   = '{SRC_ZERO, SRC_PERIOD, SRC_COMPARE_A_VALUE_UP, SRC_COMPARE_A_VALUE_DN, SRC_COMPARE_B_VALUE_UP, SRC_COMPARE_B_VALUE_DN};
  tbeip_tb_tbase i_tbeip_tb_tbase (.clk_sys_in, .go_in(go), .kind_in(kind), .timebase_count_out(cnt),
    .timebase_period_out(prd), .compare_a_value_out(cma), .compare_b_value_out(cmb), .count_up_out(up));
  tbeip_top i_tbeip_top (.clk_sys_in, .resetn_in, .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s),
    .reg_rd_in(rd_s), .reg_rdata_out(rdata), .timebase_count_in(cnt), .timebase_period_in(prd),
    .compare_a_value_in(cma), .compare_b_value_in(cmb), .count_up_in(up), .module_event_irq_out(irq),
    .event_status_flag_out(flag));
  initial forever #4 clk_sys_in = ~clk_sys_in;
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk_sys_in);
    wr_s  <= 1'b0;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk_sys_in);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_sys_in);
    rd_s <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // Counts irq pulses over a window long enough for the event pipeline
  task automatic watch(input int n, input logic e);
    int h;
    h = 0;
    // Sampling starts in the cycle of the call, so a pulse launched by the last write is seen
    repeat (n) begin
      #1 if (irq === 1'b1) h++;
      @(posedge clk_sys_in);
    end
    chk(16'(h), {15'h0, e});
  endtask
  task automatic pulse(input logic [2:0] k, input logic e);
    @(posedge clk_sys_in);
    go   <= 1'b1;
    kind <= k;
    @(posedge clk_sys_in);
    go   <= 1'b0;
    watch(6, e);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    for (int i = 0; i < 8; i++) rdc(3'(i), RD_ZERO);
    $display("reset test done");
    wr(IDX_SELECT, 16'hfff9);
    rdc(IDX_SELECT, 16'h0009);
    pulse(SRC_ZERO, 1'b0);
    wr(IDX_FORCE, 16'h0001);
    watch(6, 1'b0);
    wr(IDX_PRESCALE, 16'hfff1);
    rdc(IDX_PRESCALE, 16'h0001);
    $display("reserved test done");
    foreach (srcs[i]) begin
      wr(IDX_SELECT, {12'h000, 1'b1, srcs[i]});
      pulse(srcs[i] ^ 3'h1, 1'b0);
      pulse(srcs[i], 1'b1);
      #1 chk({15'h0000, flag}, 16'h0001);
      rdc(IDX_FLAG, 16'h0001);
      wr(IDX_CLEAR, 16'h0001);
      rdc(IDX_FLAG, 16'h0000);
    end
    for (int s = 0; s < 4; s += 3) begin
      wr(IDX_SELECT, 16'h0008 | 16'(s));
      for (int k = 1; k < 8; k++) pulse(3'(k), 1'b0);
    end
    rdc(IDX_PRESCALE, 16'h0001);
    $display("source test done");
    wr(IDX_SELECT, 16'h0009);
    wr(IDX_PRESCALE, 16'h0003);
    pulse(SRC_ZERO, 1'b0);
    rdc(IDX_PRESCALE, 16'h0007);
    pulse(SRC_ZERO, 1'b0);
    pulse(SRC_ZERO, 1'b1);
    rdc(IDX_PRESCALE, 16'h0003);
    repeat (4) pulse(SRC_ZERO, 1'b0);
    rdc(IDX_PRESCALE, 16'h000f);
    wr(IDX_CLEAR, 16'h0001);
    watch(6, 1'b1);
    wr(IDX_CLEAR, 16'h0001);
    rdc(IDX_PRESCALE, 16'h0003);
    $display("pending test done");
    wr(IDX_SELECT, 16'h0001);
    wr(IDX_PRESCALE, 16'h0002);
    repeat (3) pulse(SRC_ZERO, 1'b0);
    rdc(IDX_PRESCALE, 16'h000a);
    wr(IDX_SELECT, 16'h0009);
    watch(6, 1'b1);
    wr(IDX_CLEAR, 16'h0001);
    wr(IDX_PRESCALE, 16'h0003);
    repeat (2) pulse(SRC_ZERO, 1'b0);
    wr(IDX_PRESCALE, 16'h0002);
    watch(6, 1'b1);
    wr(IDX_CLEAR, 16'h0001);
    wr(IDX_FORCE, 16'h0001);
    watch(6, 1'b1);
    $display("enable and force test done");
    tally_and_finish();
  end
endmodule
bind tbeip_top tbeip_top_sva i_tbeip_top_sva (.clk_sys_in, .resetn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
  .reg_rd_in, .reg_rdata_out, .module_event_irq_out, .event_status_flag_out);
